// *** rtl/dqcal_consts.svh ***
`ifndef DQCAL_CONSTS_SVH
`define DQCAL_CONSTS_SVH

// Mode register addresses
`define MRA_IO_CONFIG 6'h03
`define MRA_SETPOINT_CTRL 6'h0d
`define MRA_VREF_DQ 6'h0e
`define MRA_LOWER_INVERT 6'h0f
`define MRA_PATTERN_A 6'h20
`define MRA_PATTERN_B 6'h28

// Field positions
`define SETPOINT_WRITE_BIT 6
`define SETPOINT_OPERATE_BIT 7
`define VREF_RANGE_BIT 6
`define IO_BUS_INVERSION_BIT 6
`define VREF_CODE_MSB 5

// Legal code limit
`define VREF_CODE_MAX 6'h32

// Reset values
`define VREF_DQ_RESET 7'h5d
`define SETPOINT_CTRL_RESET 8'h00
`define IO_CONFIG_RESET 8'h00
`define LOWER_INVERT_RESET 8'h55
`define PATTERN_A_RESET 8'h00
`define PATTERN_B_RESET 8'h00

// Calibration burst length in beats
`define CAL_BEATS 5'h10

`endif

// *** rtl/dqcal_pkg.sv ***
package dqcal_pkg;

  typedef logic [7:0] mr_op_t;
  typedef logic [6:0] vref_word_t;

  typedef enum logic {
    CAL_IDLE,
    CAL_BURST
  } cal_state_t;

endpackage

// *** rtl/dq_cal_serializer.sv ***
`timescale 1ns/1ps
`include "dqcal_consts.svh"

module dq_cal_serializer
  import dqcal_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  input wire logic beat,
  input wire mr_op_t pattern_a,
  input wire mr_op_t pattern_b,
  input wire mr_op_t invert,
  input wire logic bus_inversion_on,
  // Outputs
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic dmi_out,
  output logic busy
);

  cal_state_t state;
  logic [4:0] beat_idx;

  function automatic logic pattern_bit(input mr_op_t a, input mr_op_t b,
                                       input logic [4:0] idx);
    pattern_bit = idx[3] ? b[idx[2:0]] : a[idx[2:0]];
  endfunction

  assign busy = (state == CAL_BURST);

  // ========================================
  // Burst sequencing
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= CAL_IDLE;
      beat_idx <= 5'h00;
    end
    else
    begin
      case (state)
        CAL_IDLE:
        begin
          if (start)
          begin
            state <= CAL_BURST;
            beat_idx <= 5'h00;
          end
        end
        CAL_BURST:
        begin
          if (beat)
          begin
            if (beat_idx == `CAL_BEATS - 5'h01)
              state <= CAL_IDLE;
            beat_idx <= beat_idx + 5'h01;
          end
        end
        default:
          state <= CAL_IDLE;
      endcase
    end
  end

  // ========================================
  // Lane drive
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dq_out <= 8'h00;
      dmi_out <= 1'b0;
      dq_oe <= 1'b0;
    end
    else
    begin
      dq_oe <= busy && !(beat && beat_idx == `CAL_BEATS - 5'h01);
      dq_out <= {8{pattern_bit(pattern_a, pattern_b, beat_idx)}} ^ invert;
      dmi_out <= pattern_bit(pattern_a, pattern_b, beat_idx);
    end
  end

  // ========================================
  // Checks
  property p_lane_invert;
    @(posedge sys_clk) disable iff (!reset_n)
    dq_oe |-> dq_out == ({8{dmi_out}} ^ $past(invert));
  endproperty
  a_lane_invert: assert property (p_lane_invert)
    else $error("Lane inversion does not follow the invert mask");

  property p_lane_map;
    @(posedge sys_clk) disable iff (!reset_n)
    (dq_oe && $past(invert) == 8'h01) |-> (dq_out[0] != dmi_out)
      && (dq_out[7:1] == {7{dmi_out}});
  endproperty
  a_lane_map: assert property (p_lane_map)
    else $error("Invert bit zero does not map to lane zero");

  property p_dmi_true;
    @(posedge sys_clk) disable iff (!reset_n)
    busy |=> dmi_out == pattern_bit($past(pattern_a), $past(pattern_b),
                                    $past(beat_idx));
  endproperty
  a_dmi_true: assert property (p_dmi_true)
    else $error("Mask lane does not carry the true pattern");

  property p_no_bus_inversion;
    @(posedge sys_clk) disable iff (!reset_n)
    (busy && bus_inversion_on && invert == 8'h00) |=>
      dq_out == {8{dmi_out}};
  endproperty
  a_no_bus_inversion: assert property (p_no_bus_inversion)
    else $error("Calibration output was bus inverted");

endmodule // dq_cal_serializer

// *** rtl/dq_mode_registers.sv ***
`timescale 1ns/1ps
`include "dqcal_consts.svh"

// Overview of operation
// - Reference code is six bits; only 000000 to 110010 are legal.
// - Bit 6 of the reference register picks range 0 or range 1.
// - Reference register is kept as two copies, one per set point.
// - Invert bit set drives the calibration pattern inverted on that lane.
// - Invert bit n controls lower byte lane n.
// - Invert register resets to 55 hex.
// - Mask lane is never inverted and carries the true pattern.
// - No bus inversion on calibration output, even when enabled.
// - Reference write goes to the copy chosen by write select.
// - Only the copy chosen by operate select drives operation.
// - Reference read returns its operand, unused bits as zero.

module dq_mode_registers
  import dqcal_pkg::*;
(
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Mode register link from the controller
  input wire logic link_clk,
  input wire logic mr_write,
  input wire logic mr_read,
  input wire logic cal_read,
  input wire logic [5:0] mr_addr,
  input wire mr_op_t mr_op,
  // Read answer
  output mr_op_t mr_rdata,
  output logic mr_rvalid,
  // Calibration lanes
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic dmi_out,
  output logic cal_busy,
  // Active reference setting
  output logic [5:0] vref_code,
  output logic vref_range
);

  // ========================================
  // Input synchronisers
  logic [1:0] link_sync;
  logic link_prev;
  logic [1:0] wr_sync, rd_sync, cal_sync;
  logic [5:0] addr_s1, addr_s2;
  mr_op_t op_s1, op_s2;
  logic link_rise;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_sync <= 2'h0;
      link_prev <= 1'b0;
      wr_sync <= 2'h0;
      rd_sync <= 2'h0;
      cal_sync <= 2'h0;
      addr_s1 <= 6'h00;
      addr_s2 <= 6'h00;
      op_s1 <= 8'h00;
      op_s2 <= 8'h00;
    end
    else
    begin
      link_sync <= {link_sync[0], link_clk};
      link_prev <= link_sync[1];
      wr_sync <= {wr_sync[0], mr_write};
      rd_sync <= {rd_sync[0], mr_read};
      cal_sync <= {cal_sync[0], cal_read};
      addr_s1 <= mr_addr;
      addr_s2 <= addr_s1;
      op_s1 <= mr_op;
      op_s2 <= op_s1;
    end
  end

  assign link_rise = link_sync[1] && !link_prev;

  // ========================================
  // Command decode
  logic do_write, do_read;
  logic code_legal;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ref_a);
    hit = (a == ref_a);
  endfunction

  assign do_write = link_rise && wr_sync[1];
  assign do_read = link_rise && rd_sync[1];
  assign code_legal = op_s2[`VREF_CODE_MSB:0] <= `VREF_CODE_MAX;

  // ========================================
  // Mode registers
  mr_op_t setpoint_ctrl;
  mr_op_t io_config;
  mr_op_t lower_invert;
  mr_op_t pattern_a;
  mr_op_t pattern_b;
  vref_word_t vref_copy [2];
  logic wsel, osel;
  vref_word_t vref_active;

  assign wsel = setpoint_ctrl[`SETPOINT_WRITE_BIT];
  assign osel = setpoint_ctrl[`SETPOINT_OPERATE_BIT];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      setpoint_ctrl <= `SETPOINT_CTRL_RESET;
      io_config <= `IO_CONFIG_RESET;
      lower_invert <= `LOWER_INVERT_RESET;
      pattern_a <= `PATTERN_A_RESET;
      pattern_b <= `PATTERN_B_RESET;
    end
    else if (do_write)
    begin
      if (hit(addr_s2, `MRA_SETPOINT_CTRL))
        setpoint_ctrl <= op_s2;
      if (hit(addr_s2, `MRA_IO_CONFIG))
        io_config <= op_s2;
      if (hit(addr_s2, `MRA_LOWER_INVERT))
        lower_invert <= op_s2;
      if (hit(addr_s2, `MRA_PATTERN_A))
        pattern_a <= op_s2;
      if (hit(addr_s2, `MRA_PATTERN_B))
        pattern_b <= op_s2;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vref_copy[0] <= `VREF_DQ_RESET;
      vref_copy[1] <= `VREF_DQ_RESET;
    end
    else if (do_write && hit(addr_s2, `MRA_VREF_DQ) && code_legal)
      vref_copy[wsel] <= op_s2[6:0];
  end

  assign vref_active = vref_copy[osel];
  assign vref_range = vref_active[`VREF_RANGE_BIT];
  assign vref_code = vref_active[`VREF_CODE_MSB:0];

  // ========================================
  // Mode register read
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mr_rdata <= 8'h00;
      mr_rvalid <= 1'b0;
    end
    else
    begin
      mr_rvalid <= do_read;
      if (do_read)
      begin
        if (hit(addr_s2, `MRA_VREF_DQ))
          mr_rdata <= {1'b0, vref_copy[wsel]};
        else
          mr_rdata <= 8'h00;
      end
    end
  end

  // ========================================
  // Read calibration output
  dq_cal_serializer u_cal (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(link_rise && cal_sync[1]),
    .beat(link_rise),
    .pattern_a(pattern_a),
    .pattern_b(pattern_b),
    .invert(lower_invert),
    .bus_inversion_on(io_config[`IO_BUS_INVERSION_BIT]),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .dmi_out(dmi_out),
    .busy(cal_busy)
  );

  // ========================================
  // Checks
  property p_code_legal;
    @(posedge sys_clk) disable iff (!reset_n)
    vref_copy[0][5:0] <= 6'h32 && vref_copy[1][5:0] <= 6'h32;
  endproperty
  a_code_legal: assert property (p_code_legal)
    else $error("A stored reference code is reserved");

  property p_range;
    @(posedge sys_clk) disable iff (!reset_n)
    vref_range == (osel ? vref_copy[1][6] : vref_copy[0][6]);
  endproperty
  a_range: assert property (p_range)
    else $error("Range output does not follow the active copy");

  property p_other_copy_kept;
    @(posedge sys_clk) disable iff (!reset_n)
    (do_write && hit(addr_s2, `MRA_VREF_DQ) && !wsel) |=>
      $stable(vref_copy[1]);
  endproperty
  a_other_copy_kept: assert property (p_other_copy_kept)
    else $error("Write disturbed the unselected copy");

  property p_write_copy;
    @(posedge sys_clk) disable iff (!reset_n)
    (do_write && hit(addr_s2, `MRA_VREF_DQ) && code_legal) |=>
      vref_copy[$past(wsel)] == $past(op_s2[6:0]);
  endproperty
  a_write_copy: assert property (p_write_copy)
    else $error("Reference write missed the selected copy");

  property p_operate_copy;
    @(posedge sys_clk) disable iff (!reset_n)
    (!osel && !$stable(vref_copy[1]) && $stable(vref_copy[0]) &&
      $stable(osel)) |-> $stable(vref_code);
  endproperty
  a_operate_copy: assert property (p_operate_copy)
    else $error("Inactive copy changed the operating setting");

  property p_read_zero;
    @(posedge sys_clk) disable iff (!reset_n)
    do_read |=> mr_rvalid && !mr_rdata[7] &&
      (!$past(hit(addr_s2, `MRA_VREF_DQ)) ||
      mr_rdata[6:0] == $past(vref_copy[wsel]));
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("Reference read returned wrong data");

  property p_invert_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    !$stable(lower_invert) |->
      $past(do_write && hit(addr_s2, `MRA_LOWER_INVERT));
  endproperty
  a_invert_hold: assert property (p_invert_hold)
    else $error("Invert mask changed without a write");

endmodule // dq_mode_registers

// *** verif/mr_ctl_model.sv ***
`timescale 1ns/1ps
// ==========
// Controller side of the mode register link
module mr_ctl_model
  import dqcal_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Command link
  output logic link_clk,
  output logic mr_write,
  output logic mr_read,
  output logic cal_read,
  output logic [5:0] mr_addr,
  output mr_op_t mr_op
);
  initial
  begin
    link_clk = 1'b0;
    {mr_write, mr_read, cal_read} = 3'h0;
    mr_addr = 6'h00;
    mr_op = 8'h00;
  end
  // caller picks codes
  // One link rise per call, 800 ns apart
  task automatic cmd(input logic [2:0] kind, input logic [5:0] a,
                     input mr_op_t d);
  begin
    @(posedge sys_clk);
    {mr_write, mr_read, cal_read} <= kind;
    mr_addr <= a;
    mr_op <= d;
    repeat (3) @(posedge sys_clk);
    link_clk <= 1'b1;
    repeat (3) @(posedge sys_clk);
    link_clk <= 1'b0;
    @(posedge sys_clk);
    {mr_write, mr_read, cal_read} <= 3'h0;
    // Released lines show no stale value
    mr_addr <= ~a;
    mr_op <= ~d;
    @(negedge sys_clk);
  end
  endtask
endmodule // mr_ctl_model

// *** verif/dq_mode_registers_tb.sv ***
`timescale 1ns/1ps
module dq_mode_registers_tb
  import dqcal_pkg::*;
;
  logic sys_clk, reset_n, link_clk, mr_write, mr_read, cal_read;
  logic [5:0] mr_addr, vref_code;
  mr_op_t mr_op, mr_rdata, rd_seen;
  logic mr_rvalid, dq_oe, dmi_out, cal_busy, vref_range;
  logic [7:0] dq_out, w, pa, pb, iv;
  logic [1:0] s;
  vref_word_t cp [2];
  logic wsel, osel;
  int err_total, checked, rv_cnt;
  logic [5:0] corner [4] = '{6'h00, 6'h32, 6'h33, 6'h3f};

  mr_ctl_model ctl_u (.sys_clk(sys_clk), .link_clk(link_clk),
    .mr_write(mr_write), .mr_read(mr_read), .cal_read(cal_read),
    .mr_addr(mr_addr), .mr_op(mr_op));
  dq_mode_registers dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
    .link_clk(link_clk), .mr_write(mr_write), .mr_read(mr_read),
    .cal_read(cal_read), .mr_addr(mr_addr), .mr_op(mr_op),
    .mr_rdata(mr_rdata), .mr_rvalid(mr_rvalid), .dq_out(dq_out),
    .dq_oe(dq_oe), .dmi_out(dmi_out), .cal_busy(cal_busy),
    .vref_code(vref_code), .vref_range(vref_range));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (mr_rvalid === 1'b1)
    begin
      rd_seen <= mr_rdata;
      rv_cnt <= rv_cnt + 1;
    end

  // ==========
  // Checking
  task automatic chk(input logic [8:0] seen, input logic [8:0] want);
  begin
    checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  end
  endtask

  task automatic give_verdict;
  begin
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  function automatic logic [8:0] exp_lane(input logic [7:0] a, b, m,
                                          input int k);
    logic t;
    t = (k < 8) ? a[k] : b[k - 8];
    return {t, {8{t}} ^ m};
  endfunction

  // ==========
  // Link transfers
  task automatic mr_rd(input logic [5:0] a, input mr_op_t want);
    int n;
  begin
    n = rv_cnt;
    ctl_u.cmd(3'h2, a, 8'h5a);
    for (int i = 0; i < 20 && rv_cnt == n; i++)
      @(posedge sys_clk);
    if (rv_cnt == n)
    begin
      err_total++;
      give_verdict();
    end
    else
      chk({1'b0, rd_seen}, {1'b0, want});
  end
  endtask

  task automatic vref_chk;
  begin
    chk({2'h0, vref_range, vref_code}, {2'h0, cp[osel]});
    mr_rd(6'h0e, {1'b0, cp[wsel]});
  end
  endtask

  task automatic cal_run(input logic [7:0] a, b, m, input logic ld);
  begin
    ctl_u.cmd(3'h4, 6'h20, a);
    ctl_u.cmd(3'h4, 6'h28, b);
    if (ld)
      ctl_u.cmd(3'h4, 6'h0f, m);
    ctl_u.cmd(3'h1, 6'h00, 8'h00);
    @(negedge sys_clk);
    for (int k = 0; k < 16; k++)
    begin
      chk({7'h00, dq_oe, cal_busy}, 9'h003);
      chk({dmi_out, dq_out}, exp_lane(a, b, m, k));
      // A second start in mid-burst is ignored
      ctl_u.cmd({2'h0, k == 7}, 6'h00, 8'h00);
    end
    repeat (2) @(negedge sys_clk);
    chk({7'h00, dq_oe, cal_busy}, 9'h000);
  end
  endtask

  // ==========
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    {err_total, checked, rv_cnt} = '0;
    rd_seen = 8'h00;
    cp[0] = 7'h5d;
    cp[1] = 7'h5d;
    {wsel, osel} = 2'h0;
    void'($urandom(64373));
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    vref_chk();
    $display("test reset values done");
    for (int i = 0; i < 24; i++)
    begin
      w = 8'($urandom);
      w[5:0] = (i < 4) ? corner[i] : 6'($urandom_range(0, 50));
      s = 2'($urandom);
      ctl_u.cmd(3'h4, 6'h0d, {s, 6'h00});
      {osel, wsel} = s;
      ctl_u.cmd(3'h4, 6'h0e, w);
      if (w[5:0] <= 6'h32)
        cp[wsel] = w[6:0];
      vref_chk();
    end
    mr_rd(6'h0f, 8'h00);
    mr_rd(6'h3f, 8'h00);
    $display("test reference copies done");
    ctl_u.cmd(3'h4, 6'h03, 8'h40);
    for (int j = 0; j < 4; j++)
    begin
      iv = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : (j == 2) ? 8'h01 :
        8'($urandom);
      cal_run(8'($urandom), 8'($urandom), iv, 1'b1);
    end
    $display("test calibration done");
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    cp[0] = 7'h5d;
    cp[1] = 7'h5d;
    {wsel, osel} = 2'h0;
    @(negedge sys_clk);
    vref_chk();
    pa = 8'($urandom);
    pb = 8'($urandom);
    cal_run(pa, pb, 8'h55, 1'b0);
    $display("test second reset done");
    give_verdict();
  end
endmodule // dq_mode_registers_tb
